// file: src/leb_blanking.sv
// Leading-edge and state blanking for one PWM generator.
// Assumes PWM outputs come from logic on clk_i; fault, current-limit and
// blanking sources come from pins and are synchronised here.
//
// The placing of the registers and the strobed register port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "leb_regs.svh"

// Contract
// RULE_01: A high-side rising edge restarts the blanking counter only when its trigger enable is set.
// RULE_02: A high-side falling edge restarts the blanking counter only when its trigger enable is set.
// RULE_03: A low-side rising edge restarts the blanking counter only when its trigger enable is set.
// RULE_04: A low-side falling edge restarts the blanking counter only when its trigger enable is set.
// RULE_05: Edge blanking masks the fault input only while the fault blanking enable is set.
// RULE_06: Edge blanking masks the current-limit input only while the current-limit blanking enable is set.
// RULE_07: With its enable set, a high selected blanking signal suppresses fault and current-limit inputs.
// RULE_08: With its enable set, a low selected blanking signal suppresses fault and current-limit inputs.
// RULE_09: With its enable set, a high high-side output suppresses fault and current-limit inputs.
// RULE_10: With its enable set, a low high-side output suppresses fault and current-limit inputs.
// RULE_11: With its enable set, a high low-side output suppresses fault and current-limit inputs.
// RULE_12: With its enable set, a low low-side output suppresses fault and current-limit inputs.
// RULE_13: The selected blanking signal is picked by a source select field in the auxiliary control register.
// RULE_14: Control bits 9 to 6 read as zero and every implemented control bit resets to zero.
// RULE_15: An input is masked when either its enabled edge blanking is active or any enabled state condition holds.
module leb_blanking #(
	parameter int AW   = 4,
	parameter int CW   = 16,
	parameter int NSRC = 4
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	// Register port
	input  wire logic [AW-1:0] addr_i,
	input  wire logic [15:0]   wdata_i,
	input  wire logic          wr_i,
	input  wire logic          rd_i,
	output logic      [15:0]   rdata_o,
	// PWM outputs, same clock
	input  wire logic          pwm_high_side_out_i,
	input  wire logic          pwm_low_side_out_i,
	// External inputs from pins
	input  wire logic          fault_raw_i,
	input  wire logic          curlim_raw_i,
	input  wire logic [3:0]    blank_src_i,
	// Blanked results
	output logic               fault_o,
	output logic               curlim_o,
	output logic               edge_blank_o,
	output logic               state_blank_o
);

	// Register address match, used by write and read decode
	function automatic logic hit(input logic [AW-1:0] a,
	                             input logic [3:0]    ofs);
		hit = (a == AW'(ofs));
	endfunction

	// Software-visible state
	leb_pkg::leb_ctrl_t             ctrl;
	logic [`LEB_AUX_SEL_W-1:0]      blank_source_select;
	logic [CW-1:0]                  blank_duration;

	// Edge detection and blanking state
	logic                           hi_q;
	logic                           lo_q;
	logic                           hi_rise;
	logic                           hi_fall;
	logic                           lo_rise;
	logic                           lo_fall;
	logic                           restart;
	logic [CW-1:0]                  edge_count;
	logic                           edge_active;
	logic                           sel_sig;
	logic                           state_blank;
	logic                           fault_mask;
	logic                           curlim_mask;
	leb_pkg::leb_ext_t              ext;
	logic [15:0]                    next_rdata;

	// Pin inputs pass two flops before any logic sees them
	leb_sync #(
		.W ($bits(leb_pkg::leb_ext_t))
	) u_sync (
		.clk_i  (clk_i),
		.nrst_i (nrst_i),
		.d_i    ({fault_raw_i, curlim_raw_i, blank_src_i}),
		.q_o    (ext)
	);

	// Control register; reserved bits are masked off on write
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			ctrl <= leb_pkg::leb_ctrl_t'(`LEB_CTRL_RESET); // RULE_14
		end else if (wr_i && hit(addr_i, `LEB_OFS_CTRL)) begin
			ctrl <= leb_pkg::leb_ctrl_t'(wdata_i & `LEB_CTRL_WMASK); // RULE_14
		end
	end

	// Auxiliary control holds the blanking source select
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			blank_source_select <= `LEB_AUX_RESET;
		end else if (wr_i && hit(addr_i, `LEB_OFS_AUX)) begin
			blank_source_select <=
				wdata_i[`LEB_AUX_SEL_HI:`LEB_AUX_SEL_LO]; // RULE_13
		end
	end

	// Blanking duration; zero disables edge blanking entirely
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			blank_duration <= CW'(`LEB_DURATION_RESET);
		end else if (wr_i && hit(addr_i, `LEB_OFS_DURATION)) begin
			blank_duration <= CW'(wdata_i);
		end
	end

	// Previous PWM levels; reset low so an output high at release
	// counts as a rising edge on the first cycle
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			hi_q <= 1'b0;
			lo_q <= 1'b0;
		end else begin
			hi_q <= pwm_high_side_out_i;
			lo_q <= pwm_low_side_out_i;
		end
	end

	// Edge detect on the PWM outputs
	assign hi_rise = pwm_high_side_out_i & ~hi_q;
	assign hi_fall = ~pwm_high_side_out_i & hi_q;
	assign lo_rise = pwm_low_side_out_i & ~lo_q;
	assign lo_fall = ~pwm_low_side_out_i & lo_q;

	// Enabled edges restart the counter
	always_comb begin
		restart = 1'b0;
		if (ctrl.hi_rise_trig_en && hi_rise) begin
			restart = 1'b1; // RULE_01
		end
		if (ctrl.hi_fall_trig_en && hi_fall) begin
			restart = 1'b1; // RULE_02
		end
		if (ctrl.lo_rise_trig_en && lo_rise) begin
			restart = 1'b1; // RULE_03
		end
		if (ctrl.lo_fall_trig_en && lo_fall) begin
			restart = 1'b1; // RULE_04
		end
	end

	// Blanking counter
	leb_counter #(
		.CW (CW)
	) u_counter (
		.clk_i    (clk_i),
		.nrst_i   (nrst_i),
		.load_i   (restart),
		.period_i (blank_duration),
		.count_o  (edge_count),
		.active_o (edge_active)
	);

	// Selected external blanking signal
	assign sel_sig = ext.src[blank_source_select]; // RULE_13

	// State blanking: any enabled level condition
	always_comb begin
		state_blank = 1'b0;
		if (ctrl.sel_sig_high_blank_en && sel_sig) begin
			state_blank = 1'b1; // RULE_07
		end
		if (ctrl.sel_sig_low_blank_en && !sel_sig) begin
			state_blank = 1'b1; // RULE_08
		end
		if (ctrl.hi_out_high_blank_en && pwm_high_side_out_i) begin
			state_blank = 1'b1; // RULE_09
		end
		if (ctrl.hi_out_low_blank_en && !pwm_high_side_out_i) begin
			state_blank = 1'b1; // RULE_10
		end
		if (ctrl.lo_out_high_blank_en && pwm_low_side_out_i) begin
			state_blank = 1'b1; // RULE_11
		end
		if (ctrl.lo_out_low_blank_en && !pwm_low_side_out_i) begin
			state_blank = 1'b1; // RULE_12
		end
	end

	// Edge blanking is gated per input, state blanking hits both
	assign fault_mask  = (ctrl.fault_blank_en & edge_active) // RULE_05
	                   | state_blank;                        // RULE_15
	assign curlim_mask = (ctrl.curlim_blank_en & edge_active) // RULE_06
	                   | state_blank;                         // RULE_15

	// Registered results; one cycle of latency after the mask decision
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			fault_o       <= 1'b0;
			curlim_o      <= 1'b0;
			edge_blank_o  <= 1'b0;
			state_blank_o <= 1'b0;
		end else begin
			fault_o       <= ext.fault & ~fault_mask;   // RULE_05
			curlim_o      <= ext.curlim & ~curlim_mask; // RULE_06
			edge_blank_o  <= edge_active;
			state_blank_o <= state_blank;
		end
	end

	// Read decode; unmapped words read as zero
	always_comb begin
		next_rdata = `LEB_ZERO16;
		if (hit(addr_i, `LEB_OFS_CTRL)) begin
			next_rdata = ctrl; // RULE_14
		end else if (hit(addr_i, `LEB_OFS_AUX)) begin
			next_rdata[`LEB_AUX_SEL_HI:`LEB_AUX_SEL_LO] =
				blank_source_select;
		end else if (hit(addr_i, `LEB_OFS_DURATION)) begin
			next_rdata = 16'(blank_duration);
		end else if (hit(addr_i, `LEB_OFS_STATUS)) begin
			next_rdata[`LEB_STAT_EDGE]   = edge_blank_o;
			next_rdata[`LEB_STAT_STATE]  = state_blank_o;
			next_rdata[`LEB_STAT_FAULT]  = fault_o;
			next_rdata[`LEB_STAT_CURLIM] = curlim_o;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			rdata_o <= `LEB_ZERO16;
		end else if (rd_i) begin
			rdata_o <= next_rdata;
		end else begin
			rdata_o <= `LEB_ZERO16;
		end
	end

	// Checks on the blanking behaviour
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (!nrst_i);

	chk_hi_rise_load: assert property ( // RULE_01
		(ctrl.hi_rise_trig_en && hi_rise)
		|=> (edge_count == $past(blank_duration)))
		else $error("high rising edge did not restart counter");

	chk_hi_fall_load: assert property ( // RULE_02
		(ctrl.hi_fall_trig_en && hi_fall)
		|=> (edge_count == $past(blank_duration)))
		else $error("high falling edge did not restart counter");

	chk_lo_rise_load: assert property ( // RULE_03
		(ctrl.lo_rise_trig_en && lo_rise)
		|=> (edge_count == $past(blank_duration)))
		else $error("low rising edge did not restart counter");

	chk_lo_fall_load: assert property ( // RULE_04
		(ctrl.lo_fall_trig_en && lo_fall)
		|=> (edge_count == $past(blank_duration)))
		else $error("low falling edge did not restart counter");

	chk_edge_ignored: assert property ( // RULE_01
		(!restart && edge_count == '0) |=> (edge_count == '0))
		else $error("counter started without an enabled edge");

	chk_fault_edge_mask: assert property ( // RULE_05
		(ctrl.fault_blank_en && edge_active) |=> !fault_o)
		else $error("fault passed during edge blanking");

	chk_fault_pass: assert property ( // RULE_05
		(ext.fault && !ctrl.fault_blank_en && !state_blank) |=> fault_o)
		else $error("fault blanked while fault blanking is off");

	chk_curlim_edge_mask: assert property ( // RULE_06
		(ctrl.curlim_blank_en && edge_active) |=> !curlim_o)
		else $error("current limit passed during edge blanking");

	chk_curlim_pass: assert property ( // RULE_06
		(ext.curlim && !ctrl.curlim_blank_en && !state_blank)
		|=> curlim_o)
		else $error("current limit blanked while blanking is off");

	chk_sel_high_blank: assert property ( // RULE_07
		(ctrl.sel_sig_high_blank_en && sel_sig) |=> (!fault_o && !curlim_o))
		else $error("inputs passed while selected signal high");

	chk_hi_out_blank: assert property ( // RULE_09
		(ctrl.hi_out_high_blank_en && pwm_high_side_out_i)
		|=> (!fault_o && !curlim_o && state_blank_o))
		else $error("inputs passed while high side output high");

	chk_sel_low_blank: assert property ( // RULE_08
		(ctrl.sel_sig_low_blank_en && !sel_sig)
		|=> (!fault_o && !curlim_o && state_blank_o))
		else $error("inputs passed while selected signal low");

	chk_hi_low_blank: assert property ( // RULE_10
		(ctrl.hi_out_low_blank_en && !pwm_high_side_out_i)
		|=> (!fault_o && !curlim_o && state_blank_o))
		else $error("inputs passed while high side output low");

	chk_lo_high_blank: assert property ( // RULE_11
		(ctrl.lo_out_high_blank_en && pwm_low_side_out_i)
		|=> (!fault_o && !curlim_o && state_blank_o))
		else $error("inputs passed while low side output high");

	chk_lo_low_blank: assert property ( // RULE_12
		(ctrl.lo_out_low_blank_en && !pwm_low_side_out_i)
		|=> (!fault_o && !curlim_o && state_blank_o))
		else $error("inputs passed while low side output low");

	// Write mask must keep the reserved field clear at all times
	chk_rsvd_stored: assert property ( // RULE_14
		ctrl.rsvd == '0)
		else $error("reserved control bits stored nonzero");

	// With every enable clear nothing may mask, whatever the counter does
	chk_idle_pass: assert property ( // RULE_15
		(ctrl == leb_pkg::leb_ctrl_t'(`LEB_CTRL_RESET)
		 && ext.fault && ext.curlim) |=> (fault_o && curlim_o))
		else $error("inputs blanked with every enable clear");

	chk_edge_countdown: assert property ( // RULE_15
		(edge_count != '0 && !restart)
		|=> (edge_count == $past(edge_count) - CW'(1)))
		else $error("blanking counter did not count down");

	chk_rsvd_zero: assert property ( // RULE_14
		(rd_i && hit(addr_i, `LEB_OFS_CTRL))
		|=> (rdata_o[`LEB_CTRL_RSVD_HI:`LEB_CTRL_RSVD_LO] == '0))
		else $error("reserved control bits read nonzero");

	chk_edge_expiry: assert property ( // RULE_15
		(edge_count == CW'(1) && !restart) |=> !edge_active)
		else $error("blanking did not end at count expiry");

	// Main scenarios
	cov_restart: cover property (restart ##1 edge_active);
	cov_fault_edge: cover property (
		ext.fault && ctrl.fault_blank_en && edge_active ##1 !fault_o);
	cov_sel_blank: cover property (
		ctrl.sel_sig_low_blank_en && !sel_sig ##1 state_blank_o);
	cov_expiry: cover property ($fell(edge_active));

endmodule // leb_blanking
`default_nettype wire

// file: src/leb_counter.sv
// Leading-edge blanking down-counter.
// Assumes load_i is a one-cycle trigger from logic on the same clock.
`timescale 1ns/1ps
`default_nettype none

module leb_counter #(
	parameter int CW = 16
) (
	// Clock and reset
	input  wire logic          clk_i,
	input  wire logic          nrst_i,
	// Control
	input  wire logic          load_i,
	input  wire logic [CW-1:0] period_i,
	// State
	output logic      [CW-1:0] count_o,
	output logic               active_o
);

	// Restart wins over counting, so a new edge extends blanking
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			count_o <= '0;
		end else if (load_i) begin
			count_o <= period_i;
		end else if (count_o != '0) begin
			count_o <= count_o - CW'(1);
		end
	end

	assign active_o = (count_o != '0);

endmodule // leb_counter
`default_nettype wire

// file: src/leb_pkg.sv
// Types shared by the blanking block and its submodules.
// Assumes the constants of leb_regs.svh for widths.
`include "leb_regs.svh"

package leb_pkg;

	// Control register layout, most significant bit first
	typedef struct packed {
		logic       hi_rise_trig_en;
		logic       hi_fall_trig_en;
		logic       lo_rise_trig_en;
		logic       lo_fall_trig_en;
		logic       fault_blank_en;
		logic       curlim_blank_en;
		logic [3:0] rsvd;
		logic       sel_sig_high_blank_en;
		logic       sel_sig_low_blank_en;
		logic       hi_out_high_blank_en;
		logic       hi_out_low_blank_en;
		logic       lo_out_high_blank_en;
		logic       lo_out_low_blank_en;
	} leb_ctrl_t;

	// Synchronised external inputs
	typedef struct packed {
		logic       fault;
		logic       curlim;
		logic [3:0] src;
	} leb_ext_t;

endpackage

// file: src/leb_regs.svh
// Register offsets, field positions and reset values of the blanking block.
// Assumes a plain word-indexed register port with 16-bit data.
`ifndef LEB_REGS_SVH
`define LEB_REGS_SVH

// Register word indices
`define LEB_OFS_CTRL      4'h0
`define LEB_OFS_AUX       4'h1
`define LEB_OFS_DURATION  4'h2
`define LEB_OFS_STATUS    4'h3

// Control register: writable bits and reserved field
`define LEB_CTRL_RESET    16'h0000
`define LEB_CTRL_WMASK    16'hfc3f
`define LEB_CTRL_RSVD_HI  9
`define LEB_CTRL_RSVD_LO  6

// Auxiliary control: source select field
`define LEB_AUX_SEL_W     2
`define LEB_AUX_SEL_HI    1
`define LEB_AUX_SEL_LO    0
`define LEB_AUX_RESET     2'h0

// Blanking duration in module clocks
`define LEB_DURATION_RESET 16'h0000

// Status register bit positions
`define LEB_STAT_EDGE     0
`define LEB_STAT_STATE    1
`define LEB_STAT_FAULT    2
`define LEB_STAT_CURLIM   3

// Data width of the register port
`define LEB_DATA_W        16
`define LEB_ZERO16        16'h0000

`endif

// file: src/leb_sync.sv
// Two-stage synchroniser for a group of external levels.
// Assumes inputs are asynchronous to clk_i; only stage two is read.
`timescale 1ns/1ps
`default_nettype none

module leb_sync #(
	parameter int W = 6
) (
	// Clock and reset
	input  wire logic         clk_i,
	input  wire logic         nrst_i,
	// Levels
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o
);

	logic [W-1:0] meta;

	// First stage feeds only the second stage
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			meta <= '0;
			q_o  <= '0;
		end else begin
			meta <= d_i;
			q_o  <= meta;
		end
	end

endmodule // leb_sync
`default_nettype wire

// file: tb/leb_blanking_bench.sv
// Self-checking bench for the blanking block: register port, edge and
// state blanking. Assumes the partner model drives the pins.
`timescale 1ns/1ps
`default_nettype none

module leb_blanking_bench;
	logic        clk_i;
	logic        nrst_i;
	logic [3:0]  addr_i;
	logic [15:0] wdata_i;
	logic        wr_i;
	logic        rd_i;
	logic [15:0] rdata_o;
	logic        hi_set;
	logic        lo_set;
	logic        flt_set;
	logic        cl_set;
	logic [3:0]  src_set;
	logic        pwm_hi;
	logic        pwm_lo;
	logic        flt_pin;
	logic        cl_pin;
	logic [3:0]  src_pin;
	logic        fault_o;
	logic        curlim_o;
	logic        edge_blank_o;
	logic        state_blank_o;
	logic [15:0] rv;
	logic        blank;
	int          miscompares;
	int          checks_done;
	int          cycles;

	leb_pwm_model i_model (.clk_i(clk_i), .nrst_i(nrst_i),
		.hi_set_i(hi_set), .lo_set_i(lo_set), .fault_set_i(flt_set),
		.curlim_set_i(cl_set), .src_set_i(src_set),
		.pwm_high_side_out_o(pwm_hi), .pwm_low_side_out_o(pwm_lo),
		.fault_o(flt_pin), .curlim_o(cl_pin), .src_o(src_pin));

	leb_blanking i_dut (.clk_i(clk_i), .nrst_i(nrst_i), .addr_i(addr_i),
		.wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
		.pwm_high_side_out_i(pwm_hi), .pwm_low_side_out_i(pwm_lo),
		.fault_raw_i(flt_pin), .curlim_raw_i(cl_pin),
		.blank_src_i(src_pin), .fault_o(fault_o), .curlim_o(curlim_o),
		.edge_blank_o(edge_blank_o), .state_blank_o(state_blank_o));

	// 25 MHz clock
	initial clk_i = 1'b0;
	always #20 clk_i = ~clk_i;

	task automatic wrap_up();
		if (miscompares == 0 && checks_done > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask

	// Hang guard, well above the few hundred cycles the tests need
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 5000) begin
			miscompares++;
			wrap_up();
		end
	end

	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED at %0t: saw %h expected %h", $time, seen,
				exp);
		end
	endtask

	task automatic wait_n(input int n);
		repeat (n) @(posedge clk_i);
	endtask

	// One-cycle write strobe
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk_i);
		wr_i    <= 1'b1;
		addr_i  <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i    <= 1'b0;
	endtask

	// Read data stand only in the cycle after the strobe
	task automatic rd(input logic [3:0] a, output logic [15:0] d);
		@(posedge clk_i);
		rd_i   <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i   <= 1'b0;
		#1;
		d = rdata_o;
	endtask

	task automatic set_side(input int idx, input logic v);
		if (idx < 2)
			hi_set <= v;
		else
			lo_set <= v;
	endtask

	// Even index is a rising edge, odd a falling one; 0,1 high side
	task automatic edge_case(input int idx, input logic [15:0] ctl,
		input logic ee, input logic ef, input logic ec);
		logic rise;
		rise = (idx % 2) == 0;
		wr(4'h0, ctl);
		set_side(idx, !rise);
		wait_n(14);
		set_side(idx, rise);
		wait_n(5);
		#1;
		chk(edge_blank_o, ee);
		chk(fault_o, ef);
		chk(curlim_o, ec);
		wait_n(14);
		#1;
		chk(edge_blank_o, 16'h0000);
	endtask

	initial begin
		nrst_i  = 1'b0;
		addr_i  = 4'h0;
		wdata_i = 16'h0000;
		wr_i    = 1'b0;
		rd_i    = 1'b0;
		hi_set  = 1'b0;
		lo_set  = 1'b0;
		flt_set = 1'b0;
		cl_set  = 1'b0;
		src_set = 4'h0;
		wait_n(6);
		nrst_i <= 1'b1;
		// Reset values, masks and an unmapped index
		for (int i = 0; i < 4; i++) begin
			rd(i[3:0], rv);
			chk(rv, 16'h0000);
		end
		wr(4'h0, 16'hffff);
		rd(4'h0, rv);
		chk(rv, 16'hfc3f);
		wr(4'h1, 16'hffff);
		rd(4'h1, rv);
		chk(rv, 16'h0003);
		wr(4'h5, 16'hffff);
		rd(4'h5, rv);
		chk(rv, 16'h0000);
		wr(4'h2, 16'h0008);
		wr(4'h1, 16'h0002);
		flt_set <= 1'b1;
		cl_set  <= 1'b1;
		// Each trigger enabled, then disabled with the others on
		edge_case(0, 16'h8800, 1'b1, 1'b0, 1'b1);
		edge_case(0, 16'h7800, 1'b0, 1'b1, 1'b1);
		edge_case(1, 16'h4400, 1'b1, 1'b1, 1'b0);
		edge_case(1, 16'hb400, 1'b0, 1'b1, 1'b1);
		edge_case(2, 16'h2c00, 1'b1, 1'b0, 1'b0);
		edge_case(2, 16'hdc00, 1'b0, 1'b1, 1'b1);
		edge_case(3, 16'h1800, 1'b1, 1'b0, 1'b1);
		edge_case(3, 16'he800, 1'b0, 1'b1, 1'b1);
		// State blanking: enable bit b, its signal low then high
		for (int b = 0; b < 6; b++) begin
			for (int lv = 0; lv < 2; lv++) begin
				wr(4'h0, 16'h0001 << b);
				if (b < 2)
					lo_set <= lv[0];
				else if (b < 4)
					hi_set <= lv[0];
				else
					src_set <= lv[0] ? 4'h4 : 4'hb;
				wait_n(8);
				#1;
				blank = (b % 2) == lv;
				chk(state_blank_o, blank);
				chk(fault_o, !blank);
				chk(curlim_o, !blank);
			end
		end
		// All enables clear: both inputs pass, status shows them
		wr(4'h0, 16'h0000);
		wait_n(4);
		#1;
		chk(fault_o, 1'b1);
		chk(curlim_o, 1'b1);
		rd(4'h3, rv);
		chk(rv, 16'h000c);
		wrap_up();
	end
endmodule // leb_blanking_bench

`default_nettype wire

// file: tb/leb_pwm_model.sv
// Model of the PWM output stage and of the fault, current-limit and
// blanking source pins. Assumes the bench sets targets after a clock edge.
`timescale 1ns/1ps
`default_nettype none

module leb_pwm_model (
	// Clock and reset
	input  wire logic       clk_i,
	input  wire logic       nrst_i,
	// Targets from the bench
	input  wire logic       hi_set_i,
	input  wire logic       lo_set_i,
	input  wire logic       fault_set_i,
	input  wire logic       curlim_set_i,
	input  wire logic [3:0] src_set_i,
	// Levels towards the block
	output logic            pwm_high_side_out_o,
	output logic            pwm_low_side_out_o,
	output logic            fault_o,
	output logic            curlim_o,
	output logic [3:0]      src_o
);
	// Outputs follow targets one clock later, like a registered stage
	always_ff @(posedge clk_i) begin
		if (!nrst_i) begin
			pwm_high_side_out_o <= 1'b0;
			pwm_low_side_out_o  <= 1'b0;
			fault_o             <= 1'b0;
			curlim_o            <= 1'b0;
			src_o               <= 4'h0;
		end else begin
			pwm_high_side_out_o <= hi_set_i;
			pwm_low_side_out_o  <= lo_set_i;
			fault_o             <= fault_set_i;
			curlim_o            <= curlim_set_i;
			src_o               <= src_set_i;
		end
	end
endmodule // leb_pwm_model

`default_nettype wire
